//--- apdp_pkg.sv
// Purpose: Shared constants and types for the converter parallel data port.
// Assumes: Host strobes are synchronous to ref_clk_i (125 MHz).
// Notes:   Widths, field positions and cycle counts are defined here; the assertions, host model and bench also use literal values.
`default_nettype none

package apdp_pkg;

    // ----------------------------------------------------------------
    // Widths and field positions
    // ----------------------------------------------------------------
    localparam int RES_W        = 12;   // Result / register word width
    localparam int CHAN_W       = 3;    // Channel identifier width
    localparam int LO_W         = 8;    // Low data lines 0..7
    localparam int HI_W         = 3;    // Word-mode data lines 9..11
    localparam int BIT8_POS     = 8;    // Shared pin as data bit 8
    localparam int HI_LSB       = 9;    // First word bit on lines 9..11
    localparam int NIB_W        = 4;    // Upper nibble carried in byte mode
    localparam int NIB_LSB      = 8;    // Word position of upper nibble
    localparam int CHAN_LSB     = 4;    // Channel id inside high byte
    localparam int PAD_W        = 2;    // Zero pad of the 10-bit variant

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [RES_W-1:0] WORD_RST = 12'h000;
    localparam logic [LO_W-1:0]  BYTE_RST = 8'h00;
    localparam logic [HI_W-1:0]  HI_RST   = 3'h0;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int ACCESS_NS     = 30;   // Data valid after read strobe, max
    localparam int RELINQ_NS     = 50;   // Bus released after read strobe, max
    // Longest times round down to whole cycles
    localparam int ACCESS_CYC    = (ACCESS_NS * 1000) / CLK_PERIOD_PS;
    localparam int RELINQ_CYC    = (RELINQ_NS * 1000) / CLK_PERIOD_PS;

    // ----------------------------------------------------------------
    // Port sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE
    } apdp_state_t;

endpackage

`default_nettype wire

//--- apdp_port.sv
// Purpose: Parallel host data port: result reads and register writes, word or byte mode.
// Assumes: cs_n_i, rd_n_i, wr_n_i and pins are synchronous to ref_clk_i.
// Notes:   Pins are split into input, output and output enable.
`timescale 1ns/1ps
`default_nettype none

module apdp_port #(
    parameter bit TEN_BIT = 1'b0
) (
    // Clock and reset
    input  wire logic                         ref_clk_i,
    input  wire logic                         rstn_i,
    // Host strobes
    input  wire logic                         cs_n_i,
    input  wire logic                         rd_n_i,
    input  wire logic                         wr_n_i,
    input  wire logic                         word_mode_i,
    // Data lines 0..7
    input  wire logic [apdp_pkg::LO_W-1:0]    db_lo_i,
    output var  logic [apdp_pkg::LO_W-1:0]    db_lo_o,
    output var  logic                         db_lo_oe_o,
    // Shared data bit 8 / byte select pin
    input  wire logic                         shared_bit8_byte_select_i,
    output var  logic                         shared_bit8_byte_select_o,
    output var  logic                         shared_bit8_byte_select_oe_o,
    // Data lines 9..11
    input  wire logic [apdp_pkg::HI_W-1:0]    db_hi_i,
    output var  logic [apdp_pkg::HI_W-1:0]    db_hi_o,
    output var  logic                         db_hi_oe_o,
    // Converter core side
    input  wire logic [apdp_pkg::RES_W-1:0]   result_i,
    input  wire logic [apdp_pkg::CHAN_W-1:0]  result_chan_i,
    output var  logic                         rd_start_o,
    output var  logic [apdp_pkg::RES_W-1:0]   wr_data_o,
    output var  logic                         wr_valid_o
);

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_q1;
    logic rst_n;
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {rst_n, rst_q1} <= 2'h0;
        end else begin
            {rst_n, rst_q1} <= {rst_q1, 1'b1};
        end
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Left-justify the 10-bit result so both variants share one layout
    function automatic logic [apdp_pkg::RES_W-1:0] read_word(
        input logic [apdp_pkg::RES_W-1:0] res
    );
        return TEN_BIT ? {res[apdp_pkg::RES_W-apdp_pkg::PAD_W-1:0], {apdp_pkg::PAD_W{1'b0}}}
                       : res;
    endfunction
    function automatic logic [apdp_pkg::LO_W-1:0] byte_lane(
        input logic [apdp_pkg::RES_W-1:0]  word,
        input logic [apdp_pkg::CHAN_W-1:0] chan,
        input logic                        hi
    );
        return hi ? {1'b0, chan, word[apdp_pkg::NIB_LSB +: apdp_pkg::NIB_W]}
                  : word[apdp_pkg::LO_W-1:0];
    endfunction
    logic                        acc_rd;
    logic                        acc_wr;
    logic [apdp_pkg::RES_W-1:0]  exp_word;
    assign acc_rd   = !cs_n_i && !rd_n_i;
    assign acc_wr   = !cs_n_i && !wr_n_i;
    assign exp_word = read_word(result_i);

    // ----------------------------------------------------------------
    // Port state
    // ----------------------------------------------------------------
    apdp_pkg::apdp_state_t       state;
    apdp_pkg::apdp_state_t       next_state;
    logic [apdp_pkg::LO_W-1:0]   next_db_lo;
    logic                        next_db_lo_oe;
    logic                        next_b8;
    logic                        next_b8_oe;
    logic [apdp_pkg::HI_W-1:0]   next_db_hi;
    logic                        next_db_hi_oe;
    logic                        next_rd_start;
    logic                        rd_word;
    logic                        next_rd_word;
    logic                        rd_hi;
    logic                        next_rd_hi;
    // Write capture, last value sampled while the strobe was active
    logic [apdp_pkg::LO_W-1:0]   wl_lo;
    logic [apdp_pkg::LO_W-1:0]   next_wl_lo;
    logic                        wl_b8;
    logic                        next_wl_b8;
    logic [apdp_pkg::HI_W-1:0]   wl_hi;
    logic [apdp_pkg::HI_W-1:0]   next_wl_hi;
    logic                        wl_word;
    logic                        next_wl_word;
    logic [apdp_pkg::LO_W-1:0]   pend_lo;
    logic [apdp_pkg::LO_W-1:0]   next_pend_lo;
    logic [apdp_pkg::RES_W-1:0]  next_wr_data;
    logic                        next_wr_valid;
    always_comb begin
        next_state    = state;
        next_db_lo    = db_lo_o;
        next_db_lo_oe = 1'b0;
        next_b8       = shared_bit8_byte_select_o;
        next_b8_oe    = 1'b0;
        next_db_hi    = db_hi_o;
        next_db_hi_oe = 1'b0;
        next_rd_start = 1'b0;
        next_rd_word  = rd_word;
        next_rd_hi    = rd_hi;
        next_wl_lo    = wl_lo;
        next_wl_b8    = wl_b8;
        next_wl_hi    = wl_hi;
        next_wl_word  = wl_word;
        next_pend_lo  = pend_lo;
        next_wr_data  = wr_data_o;
        next_wr_valid = 1'b0;
        unique case (state)
            apdp_pkg::ST_IDLE: begin
                // Read wins when both strobes are seen together
                if (acc_rd) begin
                    next_state    = apdp_pkg::ST_READ;
                    next_rd_start = 1'b1;
                    next_rd_word  = word_mode_i;
                    next_rd_hi    = !word_mode_i && shared_bit8_byte_select_i;
                    next_db_lo_oe = 1'b1;
                    if (word_mode_i) begin
                        next_db_lo    = exp_word[apdp_pkg::LO_W-1:0];
                        next_b8       = exp_word[apdp_pkg::BIT8_POS];
                        next_b8_oe    = 1'b1;
                        next_db_hi    = exp_word[apdp_pkg::HI_LSB +: apdp_pkg::HI_W];
                        next_db_hi_oe = 1'b1;
                    end else begin
                        next_db_lo = byte_lane(exp_word, result_chan_i,
                                               shared_bit8_byte_select_i);
                    end
                end else if (acc_wr) begin
                    next_state   = apdp_pkg::ST_WRITE;
                    next_wl_lo   = db_lo_i;
                    next_wl_b8   = shared_bit8_byte_select_i;
                    next_wl_hi   = db_hi_i;
                    next_wl_word = word_mode_i;
                end
            end
            apdp_pkg::ST_READ: begin
                // Snapshot held for the whole strobe, released right after
                if (acc_rd) begin
                    next_db_lo_oe = 1'b1;
                    next_b8_oe    = rd_word;
                    next_db_hi_oe = rd_word;
                end else begin
                    next_state = apdp_pkg::ST_IDLE;
                end
            end
            apdp_pkg::ST_WRITE: begin
                if (acc_wr) begin
                    next_wl_lo = db_lo_i;
                    next_wl_b8 = shared_bit8_byte_select_i;
                    next_wl_hi = db_hi_i;
                end else begin
                    next_state = apdp_pkg::ST_IDLE;
                    if (wl_word) begin
                        next_wr_data  = {wl_hi, wl_b8, wl_lo};
                        next_wr_valid = 1'b1;
                    end else if (wl_b8) begin
                        // Lines 4..7 are zero by host contract and not used
                        next_wr_data  = {wl_lo[apdp_pkg::NIB_W-1:0], pend_lo};
                        next_wr_valid = 1'b1;
                    end else begin
                        next_pend_lo = wl_lo;
                    end
                end
            end
            default: next_state = apdp_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state                        <= apdp_pkg::ST_IDLE;
            db_lo_o                      <= apdp_pkg::BYTE_RST;
            db_lo_oe_o                   <= 1'b0;
            shared_bit8_byte_select_o    <= 1'b0;
            shared_bit8_byte_select_oe_o <= 1'b0;
            db_hi_o                      <= apdp_pkg::HI_RST;
            db_hi_oe_o                   <= 1'b0;
            rd_start_o                   <= 1'b0;
            rd_word                      <= 1'b0;
            rd_hi                        <= 1'b0;
            wl_lo                        <= apdp_pkg::BYTE_RST;
            wl_b8                        <= 1'b0;
            wl_hi                        <= apdp_pkg::HI_RST;
            wl_word                      <= 1'b0;
            pend_lo                      <= apdp_pkg::BYTE_RST;
            wr_data_o                    <= apdp_pkg::WORD_RST;
            wr_valid_o                   <= 1'b0;
        end else begin
            state                        <= next_state;
            db_lo_o                      <= next_db_lo;
            db_lo_oe_o                   <= next_db_lo_oe;
            shared_bit8_byte_select_o    <= next_b8;
            shared_bit8_byte_select_oe_o <= next_b8_oe;
            db_hi_o                      <= next_db_hi;
            db_hi_oe_o                   <= next_db_hi_oe;
            rd_start_o                   <= next_rd_start;
            rd_word                      <= next_rd_word;
            rd_hi                        <= next_rd_hi;
            wl_lo                        <= next_wl_lo;
            wl_b8                        <= next_wl_b8;
            wl_hi                        <= next_wl_hi;
            wl_word                      <= next_wl_word;
            pend_lo                      <= next_pend_lo;
            wr_data_o                    <= next_wr_data;
            wr_valid_o                   <= next_wr_valid;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n);
    property p_drive_after_rd;
        (state == apdp_pkg::ST_IDLE) && acc_rd |=> db_lo_oe_o ##0 rd_start_o;
    endproperty
    a_drive_after_rd: assert property (p_drive_after_rd)
        else $error("read strobe not answered by driven bus");
    // One cycle only: the next access may legally follow the idle cycle
    property p_release;
        $fell(acc_rd) && (state == apdp_pkg::ST_READ) |=> !db_lo_oe_o && !db_hi_oe_o;
    endproperty
    a_release: assert property (p_release)
        else $error("bus not released after read");
    property p_no_drive_on_write;
        (state == apdp_pkg::ST_WRITE) |-> !db_lo_oe_o && !db_hi_oe_o;
    endproperty
    a_no_drive_on_write: assert property (p_no_drive_on_write)
        else $error("data lines driven during write");
    property p_ten_bit_pad;
        TEN_BIT && db_lo_oe_o && !rd_hi |-> db_lo_o[apdp_pkg::PAD_W-1:0] == 2'h0;
    endproperty
    a_ten_bit_pad: assert property (p_ten_bit_pad)
        else $error("10-bit read without zero pad");
    property p_bit8_word;
        db_lo_oe_o && rd_word |-> shared_bit8_byte_select_oe_o && db_hi_oe_o;
    endproperty
    a_bit8_word: assert property (p_bit8_word)
        else $error("word read not driving bit 8 and upper lines");
    property p_bit8_byte_input;
        !rd_word || !db_lo_oe_o |-> !shared_bit8_byte_select_oe_o && !db_hi_oe_o;
    endproperty
    a_bit8_byte_input: assert property (p_bit8_byte_input)
        else $error("shared pin driven in byte mode");
    property p_low_byte;
        (state == apdp_pkg::ST_IDLE) && acc_rd && !word_mode_i
            && !shared_bit8_byte_select_i |=> db_lo_o == $past(exp_word[7:0]);
    endproperty
    a_low_byte: assert property (p_low_byte)
        else $error("low byte read mismatch");
    property p_high_byte;
        (state == apdp_pkg::ST_IDLE) && acc_rd && !word_mode_i && shared_bit8_byte_select_i
            |=> db_lo_o[3:0] == $past(exp_word[11:8])
                && db_lo_o[6:4] == $past(result_chan_i) && !db_lo_o[7];
    endproperty
    a_high_byte: assert property (p_high_byte)
        else $error("high byte read mismatch");
    property p_word_write;
        (state == apdp_pkg::ST_WRITE) && !acc_wr && wl_word
            |=> wr_valid_o && wr_data_o == $past({wl_hi, wl_b8, wl_lo});
    endproperty
    a_word_write: assert property (p_word_write)
        else $error("word write not committed");

    c_word_read:  cover property (rd_start_o && rd_word);
    c_high_read:  cover property (rd_start_o && rd_hi);
    c_word_write: cover property (wr_valid_o && wl_word);
    c_pair_write: cover property (wr_valid_o && !wl_word);

endmodule

`default_nettype wire

//--- apdp_host_model.sv
// Purpose: Behavioural host bus controller that drives the parallel data port.
// Assumes: Strobes change 1 ns after a rising edge of ref_clk_i.
// Notes:   Data sampled from the resolved wires, never from the device outputs.
`timescale 1ns/1ps
`default_nettype none

module apdp_host_model (
    // Clock and resolved wires
    input  wire logic       ref_clk_i,
    input  wire logic [7:0] db_lo_i,
    input  wire logic       shared_i,
    input  wire logic [2:0] db_hi_i,
    // Strobes and mode
    output var  logic       cs_n_o,
    output var  logic       rd_n_o,
    output var  logic       wr_n_o,
    output var  logic       word_mode_o,
    // Host side of the data pins
    output var  logic [7:0] db_lo_o,
    output var  logic       db_lo_oe_o,
    output var  logic       shared_o,
    output var  logic       shared_oe_o,
    output var  logic [2:0] db_hi_o,
    output var  logic       db_hi_oe_o
);

    initial begin
        cs_n_o      = 1'b1;
        rd_n_o      = 1'b1;
        wr_n_o      = 1'b1;
        word_mode_o = 1'b1;
        db_lo_o     = 8'h00;
        db_lo_oe_o  = 1'b0;
        shared_o    = 1'b0;
        shared_oe_o = 1'b0;
        db_hi_o     = 3'h0;
        db_hi_oe_o  = 1'b0;
    end

    // --------------------------------------------------------------
    // Read: strobe held 4 cycles, at least 30 ns
    // --------------------------------------------------------------
    task automatic read_access(input logic word, input logic upper, output logic [11:0] seen);
        @(posedge ref_clk_i);
        #1;
        word_mode_o = word;
        shared_oe_o = !word;
        shared_o    = upper;
        cs_n_o      = 1'b0;
        rd_n_o      = 1'b0;
        repeat (4) @(posedge ref_clk_i);
        seen = {db_hi_i, shared_i, db_lo_i};
        #1;
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
    endtask

    // --------------------------------------------------------------
    // Write: data held one cycle past the strobe
    // --------------------------------------------------------------
    task automatic write_access(input logic word, input logic upper, input logic [11:0] val);
        @(posedge ref_clk_i);
        #1;
        word_mode_o = word;
        shared_oe_o = 1'b1;
        shared_o    = word ? val[8] : upper;
        db_lo_o     = (!word && upper) ? {4'h0, val[11:8]} : val[7:0];
        db_lo_oe_o  = 1'b1;
        db_hi_o     = val[11:9];
        db_hi_oe_o  = word;
        cs_n_o      = 1'b0;
        wr_n_o      = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
        cs_n_o = 1'b1;
        wr_n_o = 1'b1;
        @(posedge ref_clk_i);
        #1;
        db_lo_oe_o  = 1'b0;
        db_hi_oe_o  = 1'b0;
        shared_oe_o = !word;
    endtask

endmodule

`default_nettype wire

//--- apdp_port_tb.sv
// Purpose: Self-checking bench for the parallel data port, 12-bit and 10-bit.
// Assumes: Host model drives all strobes; result and channel come from here.
// Notes:   Undriven wires show the inverse of the host's last value.
`timescale 1ns/1ps
`default_nettype none

module apdp_port_tb;

    logic        ref_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic [11:0] res     = 12'h000;
    logic [2:0]  chan    = 3'h0;
    int          fail_count = 0;
    int          tests_run  = 0;
    logic        h_cs_n, h_rd_n, h_wr_n, h_word, h_lo_oe, h_b8, h_b8_oe, h_hi_oe;
    logic [7:0]  h_lo, d_lo, t_lo;
    logic [2:0]  h_hi, d_hi, t_hi;
    logic        d_lo_oe, d_b8, d_b8_oe, d_hi_oe, d_rd_start, d_wr_valid, t_b8, t_rd_start;
    logic [11:0] d_wr_data;
    logic [11:0] snap_oe = 12'h000, ten_snap = 12'h000;
    logic [11:0] rd_pulses = 12'h000, wr_pulses = 12'h000, wr_drive = 12'h000;
    wire  [7:0]  w_lo = d_lo_oe ? d_lo : (h_lo_oe ? h_lo : ~h_lo);
    wire         w_b8 = d_b8_oe ? d_b8 : (h_b8_oe ? h_b8 : ~h_b8);
    wire  [2:0]  w_hi = d_hi_oe ? d_hi : (h_hi_oe ? h_hi : ~h_hi);

    always #4 ref_clk = ~ref_clk;

    apdp_host_model host (.ref_clk_i(ref_clk), .db_lo_i(w_lo), .shared_i(w_b8), .db_hi_i(w_hi),
        .cs_n_o(h_cs_n), .rd_n_o(h_rd_n), .wr_n_o(h_wr_n), .word_mode_o(h_word),
        .db_lo_o(h_lo), .db_lo_oe_o(h_lo_oe), .shared_o(h_b8), .shared_oe_o(h_b8_oe),
        .db_hi_o(h_hi), .db_hi_oe_o(h_hi_oe));

    apdp_port #(.TEN_BIT(1'b0)) dut (.ref_clk_i(ref_clk), .rstn_i(rstn), .cs_n_i(h_cs_n),
        .rd_n_i(h_rd_n), .wr_n_i(h_wr_n), .word_mode_i(h_word), .db_lo_i(w_lo), .db_lo_o(d_lo),
        .db_lo_oe_o(d_lo_oe), .shared_bit8_byte_select_i(w_b8), .shared_bit8_byte_select_o(d_b8),
        .shared_bit8_byte_select_oe_o(d_b8_oe), .db_hi_i(w_hi), .db_hi_o(d_hi),
        .db_hi_oe_o(d_hi_oe), .result_i(res), .result_chan_i(chan), .rd_start_o(d_rd_start),
        .wr_data_o(d_wr_data), .wr_valid_o(d_wr_valid));

    apdp_port #(.TEN_BIT(1'b1)) dut_ten (.ref_clk_i(ref_clk), .rstn_i(rstn), .cs_n_i(h_cs_n),
        .rd_n_i(h_rd_n), .wr_n_i(h_wr_n), .word_mode_i(h_word), .db_lo_i(w_lo), .db_lo_o(t_lo),
        .db_lo_oe_o(), .shared_bit8_byte_select_i(w_b8), .shared_bit8_byte_select_o(t_b8),
        .shared_bit8_byte_select_oe_o(), .db_hi_i(w_hi), .db_hi_o(t_hi), .db_hi_oe_o(),
        .result_i(res), .result_chan_i(chan), .rd_start_o(t_rd_start), .wr_data_o(),
        .wr_valid_o());

    // --------------------------------------------------------------
    // Snapshots taken in the cycle read data first appears
    // --------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (d_rd_start === 1'b1) begin
            snap_oe   <= {9'h000, d_hi_oe, d_b8_oe, d_lo_oe};
            rd_pulses <= rd_pulses + 12'h001;
        end
        if (t_rd_start === 1'b1) begin
            ten_snap <= {t_hi, t_b8, t_lo};
        end
        if (d_wr_valid === 1'b1) begin
            wr_pulses <= wr_pulses + 12'h001;
        end
        if (h_wr_n === 1'b0 && (d_lo_oe | d_b8_oe | d_hi_oe) !== 1'b0) begin
            wr_drive <= wr_drive + 12'h001;
        end
    end

    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic wait_commit();
        int n;
        n = 0;
        while (d_wr_valid !== 1'b1 && n < 8) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        repeat (2) @(posedge ref_clk);
        #1;
    endtask

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_word_read();
        logic [11:0] seen;
        logic [11:0] p;
        res  = 12'ha5c;
        chan = 3'h5;
        p    = rd_pulses;
        host.read_access(1'b1, 1'b0, seen);
        chk("word read", res, seen);
        chk("word read enables", 12'h007, snap_oe);
        chk("ten-bit word read", {res[9:0], 2'b00}, ten_snap);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("enables released", 12'h000, {9'h000, d_hi_oe, d_b8_oe, d_lo_oe});
        chk("read pulses", p + 12'h001, rd_pulses);
    endtask

    task automatic t_byte_read();
        logic [11:0] seen;
        for (int c = 0; c < 8; c++) begin
            chan = c[2:0];
            res  = 12'h3c9 + 12'(c) * 12'h107;
            host.read_access(1'b0, 1'b0, seen);
            chk("byte low", {4'h0, res[7:0]}, {4'h0, seen[7:0]});
            chk("byte read enables", 12'h001, snap_oe);
            chk("ten-bit low", {4'h0, res[5:0], 2'b00}, {4'h0, ten_snap[7:0]});
            host.read_access(1'b0, 1'b1, seen);
            chk("byte high", {5'h00, chan, res[11:8]}, {4'h0, seen[7:0]});
            chk("ten-bit high", {5'h00, chan, res[9:6]}, {4'h0, ten_snap[7:0]});
        end
    endtask

    task automatic t_word_write();
        logic [11:0] p;
        p = wr_pulses;
        host.write_access(1'b1, 1'b0, 12'h3c5);
        wait_commit();
        chk("word write", 12'h3c5, d_wr_data);
        chk("word write pulses", p + 12'h001, wr_pulses);
    endtask

    task automatic t_byte_write();
        logic [11:0] p;
        p = wr_pulses;
        host.write_access(1'b0, 1'b0, 12'h096);
        repeat (4) @(posedge ref_clk);
        #1;
        chk("low byte no commit", p, wr_pulses);
        host.write_access(1'b0, 1'b1, 12'hb00);
        wait_commit();
        chk("byte write", 12'hb96, d_wr_data);
        chk("byte write pulses", p + 12'h001, wr_pulses);
    endtask

    initial begin
        #24000;
        fail_count++;
        end_sim();
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        t_word_read();
        t_word_write();
        t_byte_read();
        t_byte_write();
        t_word_read();
        chk("no drive during writes", 12'h000, wr_drive);
        end_sim();
    end

endmodule

`default_nettype wire
